// file: verilog/timer_capture_compare_unit.sv
`timescale 1ns/10ps
// Notes on behaviour
// - capture copies the full 16-bit time base count on a selected event.
// - mode picks falling, rising, every fourth or sixteenth rising edge.
// - each capture sets the event flag; it stays until software clears it.
// - a new capture overwrites the held value, even if never read.
// - with the pin driven as output, a port write may trigger a capture.
// - mode changes may raise a false flag; nothing suppresses it.
// - prescaler clears when off, outside capture mode, and on reset.
// - switching between capture prescalers keeps the prescaler count.
// - compare matches drive high, low, toggle or leave the pin.
// - compare flag is set in the same cycle as the pin action.
// - mode 1000 presets the compare latch high, 1001 presets it low.
// - clearing control forces compare latch low; port latch untouched.
// - time base is the Timer1 count for capture and compare.
module timer_capture_compare_unit (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [15:0] time_base_count,
  input wire logic ctrl_wr,
  input wire logic [3:0] ctrl_wdata,
  input wire logic compare_wr,
  input wire logic [15:0] compare_wdata,
  input wire logic flag_clear,
  input wire logic port_direction_bit,
  input wire logic port_data_bit,
  input wire logic event_pin_in,
  output logic event_pin_out,
  output logic event_pin_oe,
  output logic [3:0] unit_mode_field,
  output logic [7:0] capture_value_high,
  output logic [7:0] capture_value_low,
  output logic event_irq_flag
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [3:0] mode_q;
  logic [15:0] value_q;
  logic [15:0] value_d;
  logic [3:0] presc_q;
  logic [3:0] presc_d;
  logic latch_q;
  logic latch_d;
  logic flag_q;
  logic flag_d;
  logic match_q;
  logic pin_q;
  logic oe_q;
  logic pin_rise;
  logic pin_fall;

  // all checks run on the core clock and sleep through reset
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // ---------------------------------------------------------------
  // pin edges
  // ---------------------------------------------------------------
  // the pad input also reflects our own drive, so a port write that
  // flips the pin while it is an output is seen as an edge here
  pin_edge_sync u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .pin_async(event_pin_in),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  wire cap_mode = (mode_q[3:2] == capture_compare_pkg::GROUP_CAP);
  wire cmp_mode = (mode_q[3:2] == capture_compare_pkg::GROUP_CMP);
  wire sel_fall = (mode_q == capture_compare_pkg::MODE_CAP_FALL);
  wire sel_rise = (mode_q == capture_compare_pkg::MODE_CAP_RISE);
  wire sel_rise4 = (mode_q == capture_compare_pkg::MODE_CAP_RISE4);
  wire sel_rise16 = (mode_q == capture_compare_pkg::MODE_CAP_RISE16);
  wire presc_last = sel_rise4 ? (presc_q == capture_compare_pkg::PRESC_LAST4)
                              : (presc_q == capture_compare_pkg::PRESC_LAST16);
  wire presc_mode = sel_rise4 | sel_rise16;

  // ---------------------------------------------------------------
  // capture event and prescaler
  // ---------------------------------------------------------------
  wire cap_event = (sel_fall & pin_fall) | (sel_rise & pin_rise)
                 | (presc_mode & pin_rise & presc_last);

  // count is not cleared between prescaler modes, only outside capture
  always_comb begin
    presc_d = presc_q;
    if (!cap_mode) begin
      presc_d = capture_compare_pkg::PRESC_RESET;
    end else if (presc_mode && pin_rise) begin
      presc_d = presc_last ? capture_compare_pkg::PRESC_RESET : presc_q + 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // compare
  // ---------------------------------------------------------------
  // timer holds a count over several core cycles, so act on match entry
  wire match_now = (time_base_count == value_q);
  wire cmp_hit = cmp_mode & match_now & ~match_q;

  always_comb begin
    latch_d = latch_q;
    if (ctrl_wr && ctrl_wdata == capture_compare_pkg::MODE_CMP_CLEAR) begin
      latch_d = 1'b1;
    end else if (ctrl_wr && ctrl_wdata == capture_compare_pkg::MODE_CMP_SET) begin
      latch_d = 1'b0;
    end else if (ctrl_wr && ctrl_wdata == capture_compare_pkg::MODE_OFF) begin
      latch_d = 1'b0;
    end else if (cmp_hit) begin
      unique case (mode_q)
        capture_compare_pkg::MODE_CMP_CLEAR: latch_d = 1'b0;
        capture_compare_pkg::MODE_CMP_SET: latch_d = 1'b1;
        capture_compare_pkg::MODE_CMP_TOGGLE: latch_d = ~latch_q;
        default: latch_d = latch_q;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // capture / compare value and flag
  // ---------------------------------------------------------------
  // capture overwrites regardless of the flag or of software reads
  assign value_d = cap_event ? time_base_count
                 : (compare_wr ? compare_wdata : value_q);
  // set wins over a clear in the same cycle
  assign flag_d = cap_event | cmp_hit | (flag_q & ~flag_clear);

  // pin drive: compare latch in compare mode, else the port data latch
  wire pin_d = cmp_mode ? latch_d : port_data_bit;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // no guard against false flags on mode change
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= capture_compare_pkg::MODE_RESET;
    end else begin
      mode_q <= ctrl_wr ? ctrl_wdata : mode_q;
    end
  end

  // one value register: a capture outranks a compare write
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      value_q <= capture_compare_pkg::COUNT_RESET;
    end else begin
      value_q <= value_d;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      presc_q <= capture_compare_pkg::PRESC_RESET;
    end else begin
      presc_q <= presc_d;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      latch_q <= 1'b0;
    end else begin
      latch_q <= latch_d;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  // match entry needs last cycle's equality
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      match_q <= 1'b0;
    end else begin
      match_q <= match_now;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin_d;
    end
  end

  // direction is a same-clock level, so it needs no synchroniser
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= ~port_direction_bit;
    end
  end

  assign event_pin_out = pin_q;
  assign event_pin_oe = oe_q;
  assign unit_mode_field = mode_q;
  assign capture_value_high = value_q[15:8];
  assign capture_value_low = value_q[7:0];
  assign event_irq_flag = flag_q;

  // ---------------------------------------------------------------
  // capture assertions
  // ---------------------------------------------------------------
  AST_CAPTURE_LOAD: assert property (cap_event |=>
    {capture_value_high, capture_value_low} == $past(time_base_count))
    else $error("capture did not load the time base count");
  AST_OVERWRITE: assert property (cap_event && event_irq_flag |=>
    {capture_value_high, capture_value_low} == $past(time_base_count))
    else $error("pending capture was not overwritten");
  AST_DIV4: assert property (sel_rise4 && pin_rise && presc_q == 4'h3 |-> cap_event)
    else $error("fourth rising edge gave no capture");
  AST_DIV16_EARLY: assert property (sel_rise16 && presc_q != 4'hf |-> !cap_event)
    else $error("sixteen prescaler captured early");
  AST_FLAG_SET: assert property (cap_event || cmp_hit |=> event_irq_flag)
    else $error("event flag not set");
  AST_FLAG_HOLD: assert property (event_irq_flag && !flag_clear |=> event_irq_flag)
    else $error("event flag dropped without clear");
  AST_PRESC_CLEAR: assert property (!cap_mode |=> presc_q == 4'h0)
    else $error("prescaler not cleared outside capture");
  AST_PRESC_KEEP: assert property (sel_rise4 && !pin_rise && ctrl_wr
    && ctrl_wdata == capture_compare_pkg::MODE_CAP_RISE16 |=> presc_q == $past(presc_q))
    else $error("prescaler cleared on prescaler switch");
  AST_PRESC_HOLD: assert property (cap_mode && !presc_mode |=> presc_q == $past(presc_q))
    else $error("prescaler moved outside a prescaled mode");
  AST_FALL_EVENT: assert property (sel_fall && pin_fall |-> cap_event)
    else $error("falling edge gave no capture");
  AST_RISE_ONLY: assert property (sel_rise && !pin_rise |-> !cap_event)
    else $error("capture without a rising edge");
  AST_PRESC_STEP: assert property (presc_mode && pin_rise && !presc_last
    |=> presc_q == $past(presc_q) + 4'h1)
    else $error("prescaler skipped a rising edge");
  AST_OFF_IDLE: assert property (!cap_mode |-> !cap_event)
    else $error("capture outside capture mode");
  AST_MODE_LOAD: assert property (ctrl_wr |=> unit_mode_field == $past(ctrl_wdata))
    else $error("mode write not taken");
  AST_FLAG_CLEAR: assert property (flag_clear && !cap_event && !cmp_hit |=> !event_irq_flag)
    else $error("flag clear not taken");

  // ---------------------------------------------------------------
  // compare assertions
  // ---------------------------------------------------------------
  AST_CMP_PIN: assert property (cmp_hit |=> event_irq_flag && event_pin_out == latch_q)
    else $error("compare flag and pin action not together");
  AST_TOGGLE: assert property (cmp_hit && mode_q == capture_compare_pkg::MODE_CMP_TOGGLE
    && !ctrl_wr |=> latch_q != $past(latch_q))
    else $error("toggle on match did not toggle");
  AST_PRESET_HI: assert property (ctrl_wr && ctrl_wdata == 4'h8 |=> latch_q)
    else $error("preset high failed");
  AST_OFF_LOW: assert property (ctrl_wr && ctrl_wdata == 4'h0 ##1 !ctrl_wr |=> !latch_q)
    else $error("clear of control did not force latch low");
  AST_PORT_PIN: assert property (!cmp_mode && !ctrl_wr |=> event_pin_out == $past(port_data_bit))
    else $error("port data latch not on pin");
  AST_PRESET_LO: assert property (ctrl_wr && ctrl_wdata == capture_compare_pkg::MODE_CMP_SET
    |=> !latch_q)
    else $error("preset low failed");
  AST_PRESET_PIN: assert property (ctrl_wr && ctrl_wdata == capture_compare_pkg::MODE_CMP_CLEAR
    ##1 !ctrl_wr && !cmp_hit |=> event_pin_out)
    else $error("preset high did not reach the pin");
  AST_CMP_DRIVE_LO: assert property (cmp_hit && mode_q == capture_compare_pkg::MODE_CMP_CLEAR
    && !ctrl_wr |=> !event_pin_out)
    else $error("match did not drive the pin low");
  AST_CMP_DRIVE_HI: assert property (cmp_hit && mode_q == capture_compare_pkg::MODE_CMP_SET
    && !ctrl_wr |=> event_pin_out)
    else $error("match did not drive the pin high");
  AST_CMP_KEEP: assert property (cmp_hit && mode_q == capture_compare_pkg::MODE_CMP_FLAG
    && !ctrl_wr |=> latch_q == $past(latch_q))
    else $error("flag-only match changed the latch");
  AST_SINGLE_HIT: assert property (cmp_hit |=> !cmp_hit)
    else $error("held match fired twice");
  AST_COMPARE_LOAD: assert property (compare_wr && !cap_event
    |=> {capture_value_high, capture_value_low} == $past(compare_wdata))
    else $error("compare value not loaded");
  AST_OE_DIR: assert property (1'b1 |=> event_pin_oe == !$past(port_direction_bit))
    else $error("pin enable does not follow the direction bit");

  // ---------------------------------------------------------------
  // coverage
  // ---------------------------------------------------------------
  COV_CAP_RISE16: cover property (sel_rise16 && cap_event);
  COV_CAP_FALL: cover property (sel_fall && cap_event);
  COV_CMP_TOGGLE: cover property (cmp_hit && mode_q == capture_compare_pkg::MODE_CMP_TOGGLE);
  COV_SET_CLEAR: cover property (cap_event && flag_clear);
  COV_PRESC_SWITCH: cover property (sel_rise4 && ctrl_wr && ctrl_wdata == capture_compare_pkg::MODE_CAP_RISE16);

endmodule : timer_capture_compare_unit

// file: verilog/capture_compare_pkg.sv
package capture_compare_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int unsigned COUNT_W = 16;
  localparam int unsigned MODE_W = 4;
  localparam int unsigned PRESC_W = 4;
  localparam int unsigned BYTE_W = 8;

  // ---------------------------------------------------------------
  // mode field encodings
  // ---------------------------------------------------------------
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] MODE_CMP_CLEAR = 4'h8;
  localparam logic [3:0] MODE_CMP_SET = 4'h9;
  localparam logic [3:0] MODE_CMP_TOGGLE = 4'ha;
  localparam logic [3:0] MODE_CMP_FLAG = 4'hb;
  // capture modes share 01xx, compare modes share 10xx
  localparam logic [1:0] GROUP_CAP = 2'h1;
  localparam logic [1:0] GROUP_CMP = 2'h2;

  // ---------------------------------------------------------------
  // prescaler terminal counts
  // ---------------------------------------------------------------
  localparam logic [3:0] PRESC_LAST4 = 4'h3;
  localparam logic [3:0] PRESC_LAST16 = 4'hf;
  localparam logic [3:0] PRESC_RESET = 4'h0;

  // ---------------------------------------------------------------
  // reset values and flag position in the peripheral flag register
  // ---------------------------------------------------------------
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [3:0] MODE_RESET = 4'h0;
  localparam int unsigned IRQ_FLAG_BIT = 2;
  localparam int unsigned SHARED_PORT_BIT = 3;

endpackage : capture_compare_pkg

// file: verilog/pin_edge_sync.sv
`timescale 1ns/10ps
module pin_edge_sync (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic pin_async,
  output logic rise,
  output logic fall
);

  logic meta_q;
  logic sync_q;
  logic prev_q;

  // ---------------------------------------------------------------
  // two-stage synchroniser, edge taken only after the second stage
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pin_async;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // one pulse per qualifying edge
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;

endmodule : pin_edge_sync

// file: testbench/pin_source.sv
`timescale 1ns/10ps
module pin_source (
  input wire logic src_level,
  input wire logic event_pin_oe,
  input wire logic event_pin_out,
  output logic pad
);
  // ---------------------------------------------------------------
  // pad resolution
  // ---------------------------------------------------------------
  // unit output wins while enabled, so port writes reach the detector
  assign pad = event_pin_oe ? event_pin_out : src_level;
endmodule : pin_source

// file: testbench/timer_capture_compare_unit_tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; $display("FAIL t=%0t got %h exp %h", $time, a, b); end end
module timer_capture_compare_unit_tb;
  logic mclk = 1'b0, rst_n = 1'b0, ctrl_wr = 1'b0, compare_wr = 1'b0, flag_clear = 1'b0;
  logic dir = 1'b1, pdata = 1'b0, src = 1'b0;
  logic [15:0] cnt = 16'h0000, cmpv = 16'h0000; // time base driven on the core clock
  logic [3:0] wd = 4'h0;
  logic pad, pout, poe, flag;
  logic [3:0] mode;
  logic [7:0] hi, lo;
  int n_errors = 0, tests_run = 0;
  // ---------------------------------------------------------------
  // design and far side
  // ---------------------------------------------------------------
  timer_capture_compare_unit uut (.mclk(mclk), .rst_n(rst_n), .time_base_count(cnt), .ctrl_wr(ctrl_wr),
    .ctrl_wdata(wd), .compare_wr(compare_wr), .compare_wdata(cmpv), .flag_clear(flag_clear),
    .port_direction_bit(dir), .port_data_bit(pdata), .event_pin_in(pad), .event_pin_out(pout),
    .event_pin_oe(poe), .unit_mode_field(mode), .capture_value_high(hi), .capture_value_low(lo),
    .event_irq_flag(flag));
  pin_source src_model (.src_level(src), .event_pin_oe(poe), .event_pin_out(pout), .pad(pad));
  initial begin
    forever #4 mclk = ~mclk;
  end
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic stop_test;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step
  task automatic wr_mode(input logic [3:0] m);
    ctrl_wr = 1'b1;
    wd = m;
    step(1);
    ctrl_wr = 1'b0;
  endtask : wr_mode
  // mode changes may raise a false flag, so settle and clear after
  task automatic set_mode(input logic [3:0] m);
    wr_mode(m);
    step(4);
    flag_clear = 1'b1;
    step(1);
    flag_clear = 1'b0;
  endtask : set_mode
  task automatic wait_flag(input logic exp);
    int i;
    for (i = 0; i < 8 && flag !== 1'b1; i++) step(1);
    if (exp && flag !== 1'b1) begin
      n_errors++;
      $display("FAIL t=%0t flag never rose", $time);
      stop_test();
    end
    `CHK(flag, exp)
  endtask : wait_flag
  // pulses wide enough to pass the synchroniser
  task automatic pulses(input int n);
    repeat (n) begin
      src = 1'b1;
      step(3);
      src = 1'b0;
      step(3);
    end
  endtask : pulses
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    `CHK(mode, 4'h0)
    `CHK({hi, lo}, 16'h0000)
    `CHK(flag, 1'b0)
    `CHK(poe, 1'b0)
  endtask : t_reset
  task automatic t_capture;
    set_mode(4'h5);
    cnt = 16'h12a5;
    src = 1'b1;
    wait_flag(1'b1);
    `CHK({hi, lo}, 16'h12a5)
    step(5);
    `CHK(flag, 1'b1)
    set_mode(4'h5);
    src = 1'b0;
    step(6);
    `CHK(flag, 1'b0)
    set_mode(4'h4);
    src = 1'b1;
    step(6);
    `CHK(flag, 1'b0)
    cnt = 16'h3c01;
    src = 1'b0;
    wait_flag(1'b1);
    `CHK({hi, lo}, 16'h3c01)
    src = 1'b1;
    step(3);
    cnt = 16'h4d2e;
    src = 1'b0;
    step(4);
    `CHK(flag, 1'b1)
    `CHK({hi, lo}, 16'h4d2e)
  endtask : t_capture
  task automatic t_presc;
    set_mode(4'h6);
    `CHK(mode, 4'h6)
    pulses(2);
    wr_mode(4'h0);
    step(1);
    set_mode(4'h6);
    pulses(3);
    `CHK(flag, 1'b0)
    cnt = 16'h0404;
    pulses(1);
    `CHK(flag, 1'b1)
    `CHK({hi, lo}, 16'h0404)
    wr_mode(4'h0);
    step(1);
    set_mode(4'h7);
    pulses(15);
    `CHK(flag, 1'b0)
    cnt = 16'hf00d;
    pulses(1);
    `CHK(flag, 1'b1)
    `CHK({hi, lo}, 16'hf00d)
    // direct switch keeps the partly advanced count
    wr_mode(4'h0);
    step(1);
    set_mode(4'h6);
    pulses(2);
    set_mode(4'h7);
    pulses(13);
    `CHK(flag, 1'b0)
    cnt = 16'h2b6e;
    pulses(1);
    `CHK(flag, 1'b1)
    `CHK({hi, lo}, 16'h2b6e)
  endtask : t_presc
  task automatic t_port;
    dir = 1'b0;
    set_mode(4'h5);
    cnt = 16'h7777;
    step(1);
    flag_clear = 1'b1; // set must win over a held clear
    pdata = 1'b1;
    wait_flag(1'b1);
    `CHK({hi, lo}, 16'h7777)
    step(1);
    `CHK(flag, 1'b0)
    flag_clear = 1'b0;
  endtask : t_port
  task automatic t_compare;
    int i;
    cmpv = 16'h5a5a;
    pdata = 1'b0;
    for (i = 0; i < 4; i++) begin
      cnt = 16'h0000;
      compare_wr = 1'b1;
      step(1);
      compare_wr = 1'b0;
      `CHK({hi, lo}, 16'h5a5a)
      set_mode(4'h8 + 4'(i));
      if (i < 2) `CHK(pout, ~i[0])
      `CHK(poe, 1'b1)
      cnt = 16'h5a5a;
      step(1);
      `CHK(pout, (i == 1))
      `CHK(flag, 1'b1)
    end
    flag_clear = 1'b1;
    step(1);
    flag_clear = 1'b0;
    step(3);
    `CHK(flag, 1'b0)
    pdata = 1'b1;
    set_mode(4'h8);
    `CHK(pout, 1'b1)
    wr_mode(4'h0);
    `CHK(pout, 1'b0)
    step(1);
    `CHK(pout, pdata)
  endtask : t_compare
  initial begin
    repeat (12) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    step(2);
    t_reset();
    t_capture();
    t_presc();
    t_port();
    t_compare();
    stop_test();
  end
endmodule : timer_capture_compare_unit_tb
